// File: bsio_addr_form.sv
// combinational bit address former
`timescale 1ns/10ps
`default_nettype none
module bsio_addr_form
   import bsio_pkg::*;
(
   bsio_addr_if.former af
);
   logic [BSIO_ADDR_W-1:0] hw_base; // base from workspace bits 1..11
   logic [BSIO_ADDR_W-1:0] disp_ext; // sign-extended displacement
   // take only the eleven base bits, dropping the lowest bit
   assign hw_base = af.base_word[BSIO_BASE_MSB:BSIO_BASE_LSB];
   // extend the sign of the displacement before adding
   assign disp_ext = {{(BSIO_ADDR_W-BSIO_DISP_W){af.disp[BSIO_DISP_W-1]}}, af.disp};
   // multi-bit operations keep the base unchanged
   assign af.bit_addr = af.use_disp ? BSIO_ADDR_W'(hw_base + disp_ext) : hw_base;
endmodule : bsio_addr_form
`default_nettype wire

// File: bsio_addr_if.sv
// interface carrying the address-forming request and result
`timescale 1ns/10ps
`default_nettype none
interface bsio_addr_if;
   import bsio_pkg::*;
   logic [15:0] base_word;                   // workspace base word
   logic [BSIO_DISP_W-1:0] disp;             // signed displacement
   logic use_disp;                           // single-bit instruction
   logic [BSIO_ADDR_W-1:0] bit_addr;         // resulting bit address
   modport requester (output base_word, output disp, output use_disp, input bit_addr);
   modport former (input base_word, input disp, input use_disp, output bit_addr);
endinterface : bsio_addr_if
`default_nettype wire

// File: bsio_periph.sv
// peripheral model behind the address decode
`timescale 1ns/10ps
`default_nettype none
module bsio_periph (
   input wire logic mclk,
   input wire logic [15:0] addr_bus,
   input wire logic serial_bit_strobe,
   input wire logic busy,
   output logic serial_input_line
);
   logic mem [0:2047]; // one stored bit per bit address
   int n_strobe = 0; // strobes seen
   logic idle_pat = 1'b0; // toggling level while not selected
   logic [2:0] last_region = 3'h0; // peripheral enabled by the last strobe
   // address decode: user parallel, system parallel, serial controller, user space
   function automatic logic [2:0] region(input logic [10:0] a);
      return (a[10:5] == 6'h00) ? 3'h1 :
         (a[10:5] == 6'h10) ? 3'h2 :
         (a[10:5] == 6'h20) ? 3'h3 :
         (a[10:9] == 2'h3) ? 3'h4 : 3'h0;
   endfunction : region
   // input level derived from the selected bit address
   function automatic logic in_bit(input logic [10:0] a);
      return a[0] ^ a[4] ^ a[7];
   endfunction : in_bit
   // capture the output bit on the shared line at each strobe
   always @(posedge mclk) begin
      idle_pat <= ~idle_pat;
      if (serial_bit_strobe) begin
         mem[addr_bus[13:3]] <= addr_bus[2];
         n_strobe <= n_strobe + 1;
         last_region <= region(addr_bus[13:3]);
      end
   end
   // level follows the bit address on the bus while busy, else toggles
   assign serial_input_line = busy ? in_bit(addr_bus[13:3]) : idle_pat;
endmodule : bsio_periph
`default_nettype wire

// File: bsio_pkg.sv
// package of constants and types for the bit-serial io addressing unit
package bsio_pkg;
   localparam int BSIO_ADDR_W = 11;              // width of bit address
   localparam int BSIO_BASE_LSB = 1;             // lowest base bit in workspace word
   localparam int BSIO_BASE_MSB = 11;            // highest base bit in workspace word
   localparam int BSIO_DISP_W = 8;               // signed displacement width
   localparam int BSIO_CNT_W = 5;                // bit count width (1..16)
   localparam logic [4:0] BSIO_MAX_BITS = 5'h10; // longest multi-bit transfer
   localparam logic [4:0] BSIO_MIN_BITS = 5'h01; // shortest multi-bit transfer
   localparam logic [15:0] BSIO_WORD_RST = 16'h0000; // data word reset value
   localparam logic [10:0] BSIO_ADDR_RST = 11'h000;  // address reset value
   // operations that use the serial port
   typedef enum logic [2:0] {
      BSIO_OP_TEST,
      BSIO_OP_SET_ONE,
      BSIO_OP_SET_ZERO,
      BSIO_OP_MULTI_OUT,
      BSIO_OP_MULTI_IN
   } bsio_op_e;
   // sequencer states
   typedef enum logic [2:0] {
      BSIO_ST_IDLE,
      BSIO_ST_ADDR,
      BSIO_ST_STROBE,
      BSIO_ST_SAMPLE,
      BSIO_ST_HOLD,
      BSIO_ST_DONE
   } bsio_state_e;
endpackage : bsio_pkg

// File: bsio_unit.sv
// bit-serial io unit: address driver and serial sequencer

// bus layout, highest line first: A0-A1 are bits 15:14 and stay zero,
// A2-A12 are bits 13:3 and carry the bit address, A13 is bit 2 and carries
// the serial output level, bits 1:0 are unused and stay zero
// the unit holds one operation at a time; a start while busy is dropped
// without any sign, so the caller must wait for the done pulse
`timescale 1ns/10ps
`default_nettype none
module bsio_unit
   import bsio_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic phase3,
   input wire logic start,
   input wire logic [2:0] op,
   input wire logic [15:0] base_word,
   input wire logic [7:0] disp,
   input wire logic [4:0] bit_count,
   input wire logic [15:0] out_data,
   input wire logic serial_input_line,
   output logic [15:0] addr_bus,
   output logic serial_bit_strobe,
   output logic busy,
   output logic done,
   output logic [15:0] in_data,
   output logic equal_bit
);
   bsio_addr_if aif ();                  // link to address former
   bsio_state_e state_reg;               // sequencer state
   bsio_op_e op_reg;                     // latched operation
   logic [BSIO_ADDR_W-1:0] addr_reg;     // current bit address
   logic [4:0] left_reg;                 // bits remaining
   logic [4:0] idx_reg;                  // current bit index
   logic [15:0] word_reg;                // outgoing data word
   logic out_bit_reg;                    // serial output level
   logic [15:0] addr_bus_reg;            // registered bus image
   logic [4:0] cnt_clamped;              // count limited to 1..16
   logic multi;                          // multi-bit operation
   logic is_out;                         // output-type operation

   // request to the address former
   // the former is purely combinational, so its result is only trusted
   // in the idle cycle that takes the start pulse
   assign aif.base_word = base_word;
   assign aif.disp = disp;
   assign aif.use_disp = (bsio_op_e'(op) != BSIO_OP_MULTI_OUT) &&
                         (bsio_op_e'(op) != BSIO_OP_MULTI_IN);
   bsio_addr_form u_form (
      .af(aif)
   );

   // count limited to the legal range
   // zero is taken as one and anything above sixteen as sixteen, so a
   // transfer always moves at least one bit and never overruns the word
   always_comb begin
      if (bit_count == 5'h00) begin
         cnt_clamped = BSIO_MIN_BITS;
      end else if (bit_count > BSIO_MAX_BITS) begin
         cnt_clamped = BSIO_MAX_BITS;
      end else begin
         cnt_clamped = bit_count;
      end
   end

   assign multi = (op_reg == BSIO_OP_MULTI_OUT) || (op_reg == BSIO_OP_MULTI_IN);
   assign is_out = (op_reg == BSIO_OP_MULTI_OUT) || (op_reg == BSIO_OP_SET_ONE) ||
                   (op_reg == BSIO_OP_SET_ZERO);

   // sequencer: address first, strobe or sample after the next phase3
   // each bit costs at least three cycles: one or more in ADDR waiting for
   // phase3, one in STROBE or SAMPLE and one in HOLD; the address therefore
   // stands for the whole of the bit, which covers the two phases that the
   // peripheral needs to answer
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_reg <= BSIO_ST_IDLE;
      end else begin
         case (state_reg)
            BSIO_ST_IDLE: begin
               // start is only looked at here
               if (start) begin
                  state_reg <= BSIO_ST_ADDR;
               end
            end
            BSIO_ST_ADDR: begin
               // address valid; wait next phase for strobe or sample
               if (phase3) begin
                  state_reg <= is_out ? BSIO_ST_STROBE : BSIO_ST_SAMPLE;
               end
            end
            BSIO_ST_STROBE, BSIO_ST_SAMPLE: begin
               state_reg <= BSIO_ST_HOLD;
            end
            BSIO_ST_HOLD: begin
               // advance to next bit or finish
               if (multi && (left_reg > BSIO_MIN_BITS)) begin
                  state_reg <= BSIO_ST_ADDR;
               end else begin
                  state_reg <= BSIO_ST_DONE;
               end
            end
            BSIO_ST_DONE: begin
               // one cycle to let done rise before the next start
               state_reg <= BSIO_ST_IDLE;
            end
            default: begin
               state_reg <= BSIO_ST_IDLE;
            end
         endcase
      end
   end

   // operation, address, count and index tracking
   // everything the sequence needs is copied at start, so the inputs may
   // change freely while the transfer runs
   always_ff @(posedge mclk) begin
      if (srst) begin
         op_reg <= BSIO_OP_TEST;
         addr_reg <= BSIO_ADDR_RST;
         left_reg <= 5'h00;
         idx_reg <= 5'h00;
         word_reg <= BSIO_WORD_RST;
      end else if (state_reg == BSIO_ST_IDLE && start) begin
         op_reg <= bsio_op_e'(op);
         addr_reg <= aif.bit_addr;
         left_reg <= aif.use_disp ? BSIO_MIN_BITS : cnt_clamped;
         idx_reg <= 5'h00;
         word_reg <= out_data;
      end else if (state_reg == BSIO_ST_HOLD && multi && left_reg > BSIO_MIN_BITS) begin
         // step the bus address after each bit
         addr_reg <= BSIO_ADDR_W'(addr_reg + 11'h001);
         left_reg <= 5'(left_reg - 5'h01);
         idx_reg <= 5'(idx_reg + 5'h01);
      end
   end

   // serial output level chosen per operation
   // the level is refreshed in every ADDR cycle, one cycle ahead of the bus
   // image, so bus and strobe always show the level of the current bit
   always_ff @(posedge mclk) begin
      if (srst) begin
         out_bit_reg <= 1'b0;
      end else if (state_reg == BSIO_ST_ADDR) begin
         case (op_reg)
            BSIO_OP_SET_ONE: out_bit_reg <= 1'b1;
            BSIO_OP_SET_ZERO: out_bit_reg <= 1'b0;
            BSIO_OP_MULTI_OUT: out_bit_reg <= word_reg[idx_reg[3:0]];
            default: out_bit_reg <= 1'b0;
         endcase
      end
   end

   // bus image: A0-A1 zero, A2-A12 address, A13 serial out, rest zero
   // the image is cleared at the edge after each idle cycle, so the last address stays on the bus through DONE and the first idle cycle
   always_ff @(posedge mclk) begin
      if (srst) begin
         addr_bus_reg <= 16'h0000;
      end else if (state_reg == BSIO_ST_IDLE) begin
         addr_bus_reg <= 16'h0000;
      end else begin
         addr_bus_reg <= {2'b00, addr_reg, out_bit_reg, 2'b00};
      end
   end
   assign addr_bus = addr_bus_reg;

   // one strobe per output bit
   // registered from the state, so it rises in the same edge that puts the
   // data bit of the current address into the bus image
   always_ff @(posedge mclk) begin
      if (srst) begin
         serial_bit_strobe <= 1'b0;
      end else begin
         serial_bit_strobe <= (state_reg == BSIO_ST_STROBE);
      end
   end

   // sampling of the serial input
   // bits land at the index of the bit in flight; a multi-bit input starts
   // from zero so that the unused upper bits read zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         in_data <= BSIO_WORD_RST;
         equal_bit <= 1'b0;
      end else if (state_reg == BSIO_ST_IDLE && start) begin
         if (bsio_op_e'(op) == BSIO_OP_MULTI_IN) begin
            in_data <= BSIO_WORD_RST; // unused left bits zero
         end
      end else if (state_reg == BSIO_ST_SAMPLE) begin
         if (op_reg == BSIO_OP_TEST) begin
            equal_bit <= serial_input_line;
         end else begin
            in_data[idx_reg[3:0]] <= serial_input_line;
         end
      end
   end

   // status outputs
   // busy falls in the same edge that raises done, so a caller never sees
   // both low at the end of a transfer; busy only rises one cycle after start is taken
   always_ff @(posedge mclk) begin
      if (srst) begin
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         busy <= (state_reg != BSIO_ST_IDLE) && (state_reg != BSIO_ST_DONE);
         done <= (state_reg == BSIO_ST_DONE);
      end
   end
endmodule : bsio_unit
`default_nettype wire

// File: bsio_unit_props.sv
// assertion checker for the bit-serial io unit
`timescale 1ns/10ps
`default_nettype none
module bsio_unit_props (
   input wire logic mclk,
   input wire logic srst,
   input wire logic phase3,
   input wire logic start,
   input wire logic [15:0] addr_bus,
   input wire logic serial_bit_strobe,
   input wire logic busy,
   input wire logic done
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   // a strobe lasts one cycle
   sequence s_pulse;
      serial_bit_strobe ##1 !serial_bit_strobe;
   endsequence
   AST_LOW_ZERO: assert property (addr_bus[1:0] == 2'h0)
      else $error("low address lines not zero");
   AST_TOP_ZERO: assert property (addr_bus[15:14] == 2'h0)
      else $error("address wider than eleven bits");
   AST_STROBE_BUSY: assert property (serial_bit_strobe |-> busy)
      else $error("strobe outside an access");
   AST_STROBE_PULSE: assert property (serial_bit_strobe |-> s_pulse)
      else $error("strobe longer than one cycle");
   AST_STROBE_PHASE: assert property (serial_bit_strobe |-> $past(phase3) || $past(phase3, 2))
      else $error("strobe without phase three");
   AST_ADDR_HOLD: assert property (serial_bit_strobe |-> $stable(addr_bus[13:3]))
      else $error("address moved under strobe");
   AST_DONE_PULSE: assert property (done |=> !done)
      else $error("done longer than one cycle");
   AST_START_BUSY: assert property (start && !busy && !done |=> ##[0:2] busy)
      else $error("start not taken");
   AST_DONE_END: assert property ($fell(busy) |-> done)
      else $error("busy fell without done");
endmodule : bsio_unit_props
`default_nettype wire

// File: testbench.sv
// self-checking testbench for the bit-serial io unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import bsio_pkg::*;
   logic mclk = 1'b0, srst = 1'b1, phase3 = 1'b0, start = 1'b0;
   logic [2:0] op = 3'h0;
   logic [15:0] base_word = 16'h0000, out_data = 16'h0000, addr_bus, in_data;
   logic [7:0] disp = 8'h00;
   logic [4:0] bit_count = 5'h00;
   logic serial_input_line, serial_bit_strobe, busy, done, equal_bit;
   logic [2:0] r_op; // random operation
   logic [15:0] r_w, r_x; // random base word and out data
   logic [7:0] r_d; // random displacement
   logic [4:0] r_c; // random bit count
   int num_errors = 0, n_tests = 0;
   bsio_unit dut (.mclk(mclk), .srst(srst), .phase3(phase3), .start(start), .op(op),
      .base_word(base_word), .disp(disp), .bit_count(bit_count), .out_data(out_data),
      .serial_input_line(serial_input_line), .addr_bus(addr_bus),
      .serial_bit_strobe(serial_bit_strobe), .busy(busy), .done(done), .in_data(in_data),
      .equal_bit(equal_bit));
   bsio_periph u_per (.mclk(mclk), .addr_bus(addr_bus), .serial_bit_strobe(serial_bit_strobe),
      .busy(busy), .serial_input_line(serial_input_line));
   initial begin
      forever #5 mclk = ~mclk;
   end
   // phase three arrives at random spacing
   always @(posedge mclk) phase3 <= 1'($urandom_range(1));
   function automatic logic fin(input logic [10:0] a);
      return a[0] ^ a[4] ^ a[7];
   endfunction : fin
   // peripheral that the decode should enable for a bit address
   function automatic logic [2:0] xreg(input logic [10:0] a);
      if (a < 11'h020) return 3'h1;
      if (a >= 11'h200 && a < 11'h220) return 3'h2;
      if (a >= 11'h400 && a < 11'h420) return 3'h3;
      if (a >= 11'h600) return 3'h4;
      return 3'h0;
   endfunction : xreg
   function automatic logic [10:0] xaddr(input logic [2:0] o, input logic [15:0] w,
                                         input logic [7:0] d);
      return w[11:1] + ((o < 3'h3) ? {{3{d[7]}}, d} : 11'h000);
   endfunction : xaddr
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic run_op(input logic [2:0] o, input logic [15:0] w, input logic [7:0] d,
                         input logic [4:0] c, input logic [15:0] x);
      int n, s0, k;
      logic [10:0] a;
      logic [15:0] ex;
      n = (c == 5'h00) ? 1 : ((c > 5'h10) ? 16 : int'(c));
      a = xaddr(o, w, d);
      ex = 16'h0000;
      s0 = u_per.n_strobe;
      repeat (2) @(posedge mclk);
      op <= o;
      base_word <= w;
      disp <= d;
      bit_count <= c;
      out_data <= x;
      start <= 1'b1;
      @(posedge mclk);
      start <= 1'b0;
      for (k = 0; k < 600 && done !== 1'b1; k++) @(negedge mclk);
      chk("done", 16'h0001, {15'h0000, done});
      chk("busy", 16'h0000, {15'h0000, busy});
      case (o)
         3'h0: chk("equal_bit", {15'h0000, fin(a)}, {15'h0000, equal_bit});
         3'h1, 3'h2: begin
            chk("set bit", {15'h0000, o == 3'h1}, {15'h0000, u_per.mem[a]});
            chk("region", {13'h0000, xreg(a)}, {13'h0000, u_per.last_region});
         end
         3'h3: begin
            for (k = 0; k < n; k++) begin
               chk("out bit", {15'h0000, x[k]}, {15'h0000, u_per.mem[11'(a + k)]});
            end
         end
         default: begin
            for (k = 0; k < n; k++) ex[k] = fin(11'(a + k));
            chk("in_data", ex, in_data);
         end
      endcase
      k = (o == 3'h3) ? n : ((o == 3'h1 || o == 3'h2) ? 1 : 0);
      chk("strobes", 16'(k), 16'(u_per.n_strobe - s0));
      $display("op %0d ended", o);
   endtask : run_op
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   // main sequence: corner cases, then random operations
   initial begin
      void'($urandom(32'h9BDC0A11));
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      run_op(3'h0, 16'hFFFF, 8'h80, 5'h00, 16'h0000);
      run_op(3'h1, 16'h0001, 8'hFF, 5'h00, 16'h0000);
      run_op(3'h2, 16'h0800, 8'h7F, 5'h00, 16'h0000);
      run_op(3'h3, 16'h0C01, 8'h55, 5'h10, 16'hA5C3);
      run_op(3'h4, 16'hF800, 8'h00, 5'h1F, 16'h0000);
      run_op(3'h3, 16'h0400, 8'h00, 5'h00, 16'h0001);
      run_op(3'h1, 16'h0400, 8'h10, 5'h00, 16'h0000);
      run_op(3'h2, 16'h0802, 8'h1E, 5'h00, 16'h0000);
      for (int i = 0; i < 40; i++) begin
         r_op = 3'($urandom_range(4));
         r_w = 16'($urandom);
         r_d = 8'($urandom);
         r_c = 5'($urandom);
         r_x = 16'($urandom);
         run_op(r_op, r_w, r_d, r_c, r_x);
      end
      results();
   end
   // watchdog against a hang
   initial begin
      #200000;
      num_errors++;
      results();
   end
endmodule : testbench
bind bsio_unit bsio_unit_props u_props (.mclk(mclk), .srst(srst), .phase3(phase3),
   .start(start), .addr_bus(addr_bus), .serial_bit_strobe(serial_bit_strobe), .busy(busy),
   .done(done));
`default_nettype wire
